// [inc/pkt_asm_pkg.sv]
// Purpose: constants shared by the recorder packet assembler
// Assumes: byte-wide output stream, 10 MHz relative time count supplied as a 48-bit value
// Notes:   header field widths follow the 24-byte generic packet header
package pkt_asm_pkg;
   localparam logic [15:0] SYNC_WORD       = 16'hEB25;
   localparam int          HDR_BYTES       = 24;
   localparam logic [31:0] MAX_PKT_BYTES   = 32'h0008_0000;
   localparam logic [31:0] MAX_SETUP_BYTES = 32'h0800_0000;
   localparam logic [7:0]  TYPE_SETUP      = 8'h01;
   localparam logic [7:0]  TYPE_ROOT_IDX   = 8'h03;
   localparam logic [7:0]  TYPE_TIME_LO    = 8'h10;
   localparam logic [7:0]  TYPE_TIME_HI    = 8'h17;
   localparam logic [7:0]  TYPE_CG_HI      = 8'h07;
   localparam int          RTC_HZ          = 10_000_000;
   localparam int          GEN_LIMIT_MS    = 100;
   localparam int          COMMIT_LIMIT_MS = 1000;
   localparam logic [47:0] GEN_LIMIT_TICKS = 48'(RTC_HZ / 1000 * GEN_LIMIT_MS);
   localparam logic [47:0] COMMIT_TICKS    = 48'(RTC_HZ / 1000 * COMMIT_LIMIT_MS);
   localparam logic [1:0]  CK_NONE         = 2'h0;
   localparam logic [1:0]  CK_8            = 2'h1;
   localparam logic [1:0]  CK_16           = 2'h2;
   localparam logic [1:0]  CK_32           = 2'h3;
   localparam logic [7:0]  FILL_BYTE       = 8'h00;
   localparam logic [7:0]  RSVD_ZERO       = 8'h00;
endpackage : pkt_asm_pkg

// [src/trailer_sum.sv]
// Purpose: running data checksum over body bytes
// Assumes: sum of bytes, truncated to the selected checksum width
// Notes:   cleared at the start of each packet
`timescale 1ns/10ps
module trailer_sum (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // control
   input  wire logic        clr,
   input  wire logic        add,
   input  wire logic [7:0]  data,
   // result
   output logic      [31:0] sum
);
   // accumulate body bytes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sum <= 32'h0000_0000;
      end else if (clr) begin
         sum <= 32'h0000_0000;
      end else if (add) begin
         sum <= sum + {24'h00_0000, data};
      end
   end
endmodule : trailer_sum

// [src/recorder_packet_assembler.sv]
// Purpose: frames a byte source into header, body, filler and checksum trailer
// Assumes: source presents bytes with valid, sink takes bytes with ready
// Notes:   one packet at a time, header built from latched per-packet values
`timescale 1ns/10ps
module recorder_packet_assembler #(
   parameter int DEPTH = 4096
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // recording control
   input  wire logic        rec_start,
   input  wire logic        rec_stop,
   input  wire logic        index_en,
   input  wire logic [47:0] rtc,
   // source packet description, sampled with the first byte
   input  wire logic [15:0] chan_id,
   input  wire logic [7:0]  data_type,
   input  wire logic [7:0]  type_version,
   input  wire logic [7:0]  pkt_flags,
   input  wire logic [1:0]  ck_sel,
   input  wire logic [31:0] chan_word,
   input  wire logic [31:0] chan_word_rsvd,
   // source bytes
   input  wire logic        src_valid,
   input  wire logic [7:0]  src_data,
   input  wire logic        src_last,
   output logic             src_ready,
   // output stream
   output logic             out_valid,
   output logic [7:0]       out_data,
   output logic             out_sop,
   output logic             out_eop,
   input  wire logic        out_ready,
   // status
   output logic             order_err,
   output logic             commit_late
);
   typedef enum logic [2:0] {S_IDLE, S_FILL, S_HDR, S_BODY, S_PAD, S_CK} st_e;

   st_e         st_r, st_nxt;
   logic [7:0]  buf_mem [DEPTH];
   logic [$clog2(DEPTH):0] cnt_r;
   logic [4:0]  idx_r;
   logic [31:0] body_r;
   logic [47:0] t0_r;
   logic [7:0]  seq_r;
   logic [1:0]  ck_r;
   logic [7:0]  type_r;
   logic [7:0]  ver_r;
   logic [7:0]  flg_r;
   logic [15:0] ch_r;
   // recording order state
   logic        seen_setup_r;
   logic        seen_time_r;
   logic        seen_root_r;
   logic        closed_r;
   logic [31:0] chan_word_lat;
   logic [7:0]  ver_seen_r [256];
   logic [255:0] ver_set_r;
   logic [31:0] sum;
   // output and status flops
   logic        o_valid_r;
   logic        o_sop_r;
   logic        o_eop_r;
   logic        err_r;
   logic        late_r;
   logic [7:0]  o_data_r;

   // decode of type classes
   wire is_setup = type_r == pkt_asm_pkg::TYPE_SETUP;
   wire is_cg    = type_r <= pkt_asm_pkg::TYPE_CG_HI;
   wire is_time  = type_r >= pkt_asm_pkg::TYPE_TIME_LO && type_r <= pkt_asm_pkg::TYPE_TIME_HI;
   wire is_root  = type_r == pkt_asm_pkg::TYPE_ROOT_IDX;
   wire [2:0] ck_len = ck_r == pkt_asm_pkg::CK_32 ? 3'd4 :
                       ck_r == pkt_asm_pkg::CK_16 ? 3'd2 :
                       ck_r == pkt_asm_pkg::CK_8  ? 3'd1 : 3'd0;
   // data length: channel word plus body bytes
   wire [31:0] data_len = body_r + 32'd4;
   wire [31:0] raw_len  = 32'(pkt_asm_pkg::HDR_BYTES) + data_len + {29'd0, ck_len};
   wire [1:0]  pad_n    = 2'(3'd4 - {1'b0, raw_len[1:0]});
   wire [31:0] pkt_len  = raw_len + {30'd0, pad_n};
   wire [31:0] limit    = is_setup ? pkt_asm_pkg::MAX_SETUP_BYTES
                                   : pkt_asm_pkg::MAX_PKT_BYTES;
   wire        room_ok  = raw_len + 32'd8 <= limit && cnt_r < ($clog2(DEPTH)+1)'(DEPTH);
   wire        aged     = !is_cg && (rtc - t0_r) >= pkt_asm_pkg::GEN_LIMIT_TICKS;
   wire        take     = st_r == S_FILL && src_valid;
   wire        first    = take && cnt_r == '0;
   // a dropped first byte never closes a packet, so no empty packet leaves
   wire        ship     = st_r == S_FILL &&
                          ((accept && src_last) ||
                           (cnt_r != '0 && (!room_ok || aged)));
   wire        adv      = !o_valid_r || out_ready;
   // order check of the type being latched
   wire        setup_in = data_type == pkt_asm_pkg::TYPE_SETUP;
   wire        time_in  = data_type >= pkt_asm_pkg::TYPE_TIME_LO &&
                          data_type <= pkt_asm_pkg::TYPE_TIME_HI;
   wire        bad_ord  = closed_r || (setup_in && seen_time_r) ||
                          (!setup_in && !seen_setup_r) ||
                          (!setup_in && !time_in && !seen_time_r) ||
                          (index_en && seen_root_r) ||
                          (ver_set_r[data_type] &&
                           ver_seen_r[data_type] != type_version);
   wire        accept   = take && !(first && bad_ord);

   assign src_ready = st_r == S_FILL && !(cnt_r != '0 && (!room_ok || aged));

   // header byte select
   function automatic logic [7:0] hdr_byte(input logic [4:0] i, input logic [31:0] cs);
      logic [7:0] b;
      b = 8'h00;
      unique case (i)
         5'd0:  b = pkt_asm_pkg::SYNC_WORD[7:0];
         5'd1:  b = pkt_asm_pkg::SYNC_WORD[15:8];
         5'd2:  b = ch_r[7:0];
         5'd3:  b = ch_r[15:8];
         5'd4,5'd5,5'd6,5'd7: b = pkt_len[8*(i-5'd4) +: 8];
         5'd8,5'd9,5'd10,5'd11: b = data_len[8*(i-5'd8) +: 8];
         5'd12: b = ver_r;
         5'd13: b = seq_r;
         5'd14: b = flg_r;
         5'd15: b = type_r;
         5'd16,5'd17,5'd18,5'd19,5'd20,5'd21: b = t0_r[8*(i-5'd16) +: 8];
         5'd22: b = cs[7:0];
         5'd23: b = cs[15:8];
         5'd24,5'd25,5'd26,5'd27: b = chan_word_lat[8*(i-5'd24) +: 8];
         default: b = 8'h00;
      endcase
      return b;
   endfunction : hdr_byte

   logic [15:0] hdr_cs;
   // header checksum: 16-bit sum of the first eleven header words
   always_comb begin
      hdr_cs = pkt_asm_pkg::SYNC_WORD + ch_r + pkt_len[15:0] + pkt_len[31:16]
             + data_len[15:0] + data_len[31:16] + {seq_r, ver_r} + {type_r, flg_r}
             + t0_r[15:0] + t0_r[31:16] + t0_r[47:32];
   end

   // state transitions
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         S_IDLE: if (rec_start) st_nxt = S_FILL;
         S_FILL: if (ship) st_nxt = S_HDR;
         S_HDR:  if (adv && idx_r == 5'd27) st_nxt = S_BODY;
         S_BODY: if (adv && 32'(cnt_r) == body_r - 32'd1) st_nxt = pad_n != 0 ? S_PAD :
                                                 ck_len != 0 ? S_CK : S_FILL;
         S_PAD:  if (adv && idx_r == 5'(pad_n) - 5'd1) st_nxt = ck_len != 0 ? S_CK : S_FILL;
         S_CK:   if (adv && idx_r == 5'(ck_len) - 5'd1) st_nxt = S_FILL;
      endcase
      if (st_r == S_FILL && !ship && rec_stop) st_nxt = cnt_r == '0 ? S_IDLE : S_HDR;
   end

   trailer_sum u_sum (
      .clk  (clk),
      .rst  (rst),
      .clr  (st_r == S_IDLE || (st_r != S_FILL && st_nxt == S_FILL)),      // cleared after trailer
      .add  (accept),
      .data (src_data),
      .sum  (sum)
   );

   // byte buffer for the body
   always_ff @(posedge clk) begin
      if (accept) buf_mem[cnt_r[$clog2(DEPTH)-1:0]] <= src_data;
   end

   // version memory per data type
   always_ff @(posedge clk) begin
      if (first && !bad_ord) ver_seen_r[data_type] <= type_version;
   end

   // per-packet latches and counters
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r          <= S_IDLE;
         cnt_r         <= '0;
         idx_r         <= '0;
         body_r        <= '0;
         t0_r          <= '0;
         seq_r         <= '0;
         ck_r          <= '0;
         type_r        <= '0;
         ver_r         <= '0;
         flg_r         <= '0;
         ch_r          <= '0;
         seen_setup_r  <= 1'b0;
         seen_time_r   <= 1'b0;
         seen_root_r   <= 1'b0;
         closed_r      <= 1'b0;
         ver_set_r     <= '0;
         chan_word_lat <= '0;
         err_r         <= 1'b0;
         late_r        <= 1'b0;
      end else begin
         st_r <= st_nxt;
         err_r <= take && first && bad_ord;
         // new recording forgets order history and restarts the sequence
         if (st_r == S_IDLE && rec_start) begin
            seen_setup_r <= 1'b0;
            seen_time_r  <= 1'b0;
            seen_root_r  <= 1'b0;
            closed_r     <= 1'b0;
            ver_set_r    <= '0;
            seq_r        <= '0;
         end
         // header values frozen with the first accepted byte
         if (first && !bad_ord) begin
            t0_r   <= rtc;
            ch_r   <= chan_id;
            type_r <= data_type;
            flg_r  <= pkt_flags;
            ver_r  <= type_version;
            ck_r   <= ck_sel;
            chan_word_lat <= chan_word & ~chan_word_rsvd;
            ver_set_r[data_type] <= 1'b1;
            seen_setup_r <= seen_setup_r | setup_in;
            seen_time_r <= seen_time_r | time_in;
         end
         if (accept) cnt_r <= cnt_r + 1'b1;
         if (ship || (st_nxt == S_HDR && st_r == S_FILL)) begin
            body_r <= 32'(cnt_r) + (accept ? 32'd1 : 32'd0); idx_r <= '0;
            cnt_r <= '0;
         end
         // lateness judged when the sink takes the final byte
         if (o_valid_r && out_ready && o_eop_r) begin
            late_r <= !is_cg && (rtc - t0_r) > pkt_asm_pkg::COMMIT_TICKS;
         end
         if (adv && st_r != S_IDLE && st_r != S_FILL) begin
            idx_r <= (st_nxt != st_r) ? 5'd0 : idx_r + 5'd1;
            if (st_r == S_BODY) cnt_r <= cnt_r + 1'b1;
            if (st_r == S_BODY && st_nxt != S_BODY) cnt_r <= '0;
         end
         if (st_r != S_FILL && st_r != S_IDLE && st_nxt == S_FILL) begin
            seq_r <= seq_r + 8'd1;
            if (is_root && index_en) begin
               seen_root_r <= 1'b1;
               closed_r    <= 1'b1;
            end
         end
      end
   end

   // output byte mux
   wire [7:0] ck_byte = sum[8*idx_r[1:0] +: 8];
   wire [7:0] nxt_byte = st_r == S_HDR  ? hdr_byte(idx_r, {16'h0000, hdr_cs}) :
                         st_r == S_BODY ? buf_mem[cnt_r[$clog2(DEPTH)-1:0]] :
                         st_r == S_PAD  ? pkt_asm_pkg::FILL_BYTE : ck_byte;
   wire busy = st_r == S_HDR || st_r == S_BODY || st_r == S_PAD || st_r == S_CK;

   // output registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         o_valid_r <= 1'b0;
         o_data_r  <= 8'h00;
         o_sop_r   <= 1'b0;
         o_eop_r   <= 1'b0;
      end else if (adv) begin
         o_valid_r <= busy;
         o_data_r  <= nxt_byte;
         o_sop_r   <= st_r == S_HDR && idx_r == 5'd0;
         o_eop_r   <= busy && st_nxt == S_FILL;
      end
   end

   assign out_valid   = o_valid_r;
   assign out_data    = o_data_r;
   assign out_sop     = o_sop_r;
   assign out_eop     = o_eop_r;
   assign order_err   = err_r;
   assign commit_late = late_r;
endmodule : recorder_packet_assembler

// [verif/pkt_asm_monitor.sv]
// Purpose: port checker for the packet assembler output stream
// Assumes: little endian header, data type in header byte 15
// Notes:   byte index and length fields rebuilt from accepted bytes
`timescale 1ns/10ps
module pkt_asm_monitor (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // output stream
   input wire logic       out_valid,
   input wire logic [7:0] out_data,
   input wire logic       out_sop,
   input wire logic       out_eop,
   input wire logic       out_ready,
   // status
   input wire logic       order_err
);
   logic [31:0] bidx_r, plen_r, dlen_r;
   logic [7:0]  typ_r;
   wire         acc = out_valid && out_ready;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // byte index and header fields of the packet in flight
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bidx_r <= '0;
         plen_r <= '0;
         dlen_r <= '0;
         typ_r  <= '0;
      end else if (acc) begin
         bidx_r <= out_eop ? '0 : bidx_r + 32'h0000_0001;
         if (bidx_r >= 4 && bidx_r <= 7) plen_r <= {out_data, plen_r[31:8]};
         if (bidx_r >= 8 && bidx_r <= 11) dlen_r <= {out_data, dlen_r[31:8]};
         if (bidx_r == 15) typ_r <= out_data;
      end
   end
   a_sync_low: assert property (out_valid && bidx_r == 0 |-> out_sop && out_data == 8'h25)
      else $error("first sync byte wrong");
   a_sync_high: assert property (out_valid && bidx_r == 1 |-> out_data == 8'hEB)
      else $error("second sync byte wrong");
   a_len_align: assert property (out_valid && bidx_r == 4 |-> out_data[1:0] == 2'b00)
      else $error("packet length not word aligned");
   a_size_cap: assert property (out_valid && bidx_r == 16 && typ_r != 8'h01 |->
      plen_r <= pkt_asm_pkg::MAX_PKT_BYTES)
      else $error("packet too large");
   a_setup_cap: assert property (out_valid && bidx_r == 16 |-> plen_r <= pkt_asm_pkg::MAX_SETUP_BYTES)
      else $error("setup packet too large");
   a_len_match: assert property (acc && out_eop |-> bidx_r + 1 == plen_r)
      else $error("length field differs from bytes sent");
   a_trailer_span: assert property (acc && out_eop |-> plen_r - dlen_r >= 24 && plen_r - dlen_r <= 31)
      else $error("filler or checksum span wrong");
   a_not_empty: assert property (acc && out_eop |-> bidx_r >= 28)
      else $error("empty packet emitted");
   a_eop_gap: assert property (acc && out_eop |=> !out_valid || out_sop)
      else $error("packet start missing");
   c_packet: cover property (acc && out_eop);
   c_stall: cover property (out_valid && !out_ready);
   c_refused: cover property (order_err);
endmodule : pkt_asm_monitor
bind recorder_packet_assembler pkt_asm_monitor u_mon (.clk(clk), .rst(rst), .out_valid(out_valid),
   .out_data(out_data), .out_sop(out_sop), .out_eop(out_eop), .out_ready(out_ready), .order_err(order_err));

// [verif/pkt_sink.sv]
// Purpose: downstream stream consumer that stalls on command
// Assumes: one packet inspected at a time by the bench
// Notes:   slow takes a byte only every other cycle, hold takes none
`timescale 1ns/10ps
module pkt_sink (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // stream in
   input wire logic       out_valid,
   input wire logic [7:0] out_data,
   input wire logic       out_sop,
   input wire logic       out_eop,
   output logic           out_ready
);
   logic [7:0] pkt[$];
   int         npkts = 0;
   bit         slow = 0, hold = 0, ph = 0;
   // ready pattern and capture of accepted bytes
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         out_ready <= 1'b0;
      end else begin
         out_ready <= !hold && !(slow && ph);
         ph <= !ph;
         if (out_valid && out_ready && out_sop) pkt.delete();
         if (out_valid && out_ready) pkt.push_back(out_data);
         if (out_valid && out_ready && out_eop) npkts++;
      end
   end
endmodule : pkt_sink

// [verif/tb_top.sv]
// Purpose: self-checking bench for the recorder packet assembler
// Assumes: time count moves only when a scenario bumps it
// Notes:   packets judged by size, length, sequence, channel word, filler and checksum fields from the sink capture
`timescale 1ns/10ps
module tb_top;
   logic clk = 0, rst = 1, rec_start = 0, index_en = 0, src_valid = 0, src_last = 0;
   logic [47:0] rtc = '0;
   logic [7:0]  data_type = '0, type_version = '0, src_data = '0;
   logic [1:0]  ck_sel = '0;
   logic [31:0] chan_word = '0, chan_word_rsvd = '0;
   wire         src_ready, out_valid, out_sop, out_eop, out_ready, order_err, commit_late;
   wire [7:0]   out_data;
   int          n_errors = 0, checks_done = 0, n_oerr = 0, cyc = 0;
   recorder_packet_assembler dut (.clk(clk), .rst(rst), .rec_start(rec_start), .rec_stop(1'b0),
      .index_en(index_en), .rtc(rtc), .chan_id(16'h0005), .data_type(data_type),
      .type_version(type_version), .pkt_flags(8'h00), .ck_sel(ck_sel), .chan_word(chan_word),
      .chan_word_rsvd(chan_word_rsvd), .src_valid(src_valid), .src_data(src_data),
      .src_last(src_last), .src_ready(src_ready), .out_valid(out_valid), .out_data(out_data),
      .out_sop(out_sop), .out_eop(out_eop), .out_ready(out_ready), .order_err(order_err),
      .commit_late(commit_late));
   pkt_sink sink (.clk(clk), .rst(rst), .out_valid(out_valid), .out_data(out_data),
      .out_sop(out_sop), .out_eop(out_eop), .out_ready(out_ready));
   // clock, refusal count and hang guard
   initial forever #20 clk = ~clk;
   always @(posedge clk) if (order_err === 1'b1) n_oerr++;
   always @(posedge clk) if (++cyc == 5000) begin
      n_errors++;
      print_verdict();
   end
   task automatic cmp(input string what, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic send(input logic [7:0] ty, ver, input logic [1:0] ck, input int n,
         input logic [31:0] cw, msk, input bit last);
      @(posedge clk);
      {data_type, type_version, ck_sel, chan_word, chan_word_rsvd} <= {ty, ver, ck, cw, msk};
      for (int i = 0; i < n; i++) begin
         src_valid <= 1'b1;
         src_data  <= 8'(i + 1);
         src_last  <= last && (i == n - 1);
         @(posedge clk);
         while (src_ready !== 1'b1) @(posedge clk);
      end
      src_valid <= 1'b0;
   endtask : send
   task automatic wait_pkt(input int want);
      for (int k = 0; k < 300 && sink.npkts != want; k++) @(posedge clk);
      cmp("packet count", 32'(want), 32'(sink.npkts));
   endtask : wait_pkt
   task automatic chk_pkt(input logic [1:0] ck, input int n, input logic [31:0] cwx,
         input logic [7:0] seq);
      logic [7:0]  p[$];
      int          dl, cb, pl;
      logic [31:0] s;
      p  = sink.pkt;
      dl = 4 + n;
      cb = (ck == 2'h3) ? 4 : int'(ck);
      pl = (24 + dl + cb + 3) / 4 * 4;
      s  = 32'(n * (n + 1) / 2);
      cmp("size", 32'(pl), 32'(p.size()));
      if (p.size() != pl) return;
      cmp("sync", 32'h0000_EB25, {16'h0000, p[1], p[0]});
      cmp("plen", 32'(pl), {p[7], p[6], p[5], p[4]});
      cmp("dlen", 32'(dl), {p[11], p[10], p[9], p[8]});
      cmp("seq", 32'(seq), 32'(p[13]));
      cmp("cword", cwx, {p[27], p[26], p[25], p[24]});
      for (int i = 24 + dl; i < pl - cb; i++) cmp("fill", 32'h0, 32'(p[i]));
      for (int i = 0; i < cb; i++) cmp("csum", 32'(s[8*i +: 8]), 32'(p[pl - cb + i]));
   endtask : chk_pkt
   task automatic t_setup;
      sink.slow = 1'b1;
      send(8'h01, 8'h07, 2'h3, 5, '0, '0, 1'b1);
      wait_pkt(1);
      chk_pkt(2'h3, 5, '0, 8'h00);
      send(8'h01, 8'h07, 2'h1, 3, '0, '0, 1'b1);
      wait_pkt(2);
      chk_pkt(2'h1, 3, '0, 8'h01);
      sink.slow = 1'b0;
      $display("test setup done");
   endtask : t_setup
   task automatic t_order;
      send(8'h21, 8'h06, 2'h2, 1, '0, '0, 1'b1);
      repeat (20) @(posedge clk);
      cmp("refused early", 32'd1, 32'(n_oerr));
      send(8'h11, 8'h06, 2'h0, 3, 32'hFFFF_FFFF, 32'hF000_0000, 1'b1);
      wait_pkt(3);
      chk_pkt(2'h0, 3, 32'h0FFF_FFFF, 8'h02);
      send(8'h21, 8'h06, 2'h2, 2, '0, '0, 1'b1);
      wait_pkt(4);
      chk_pkt(2'h2, 2, '0, 8'h03);
      send(8'h21, 8'h05, 2'h2, 1, '0, '0, 1'b1);
      repeat (20) @(posedge clk);
      cmp("version change", 32'd2, 32'(n_oerr));
      $display("test order done");
   endtask : t_order
   task automatic t_age;
      send(8'h21, 8'h06, 2'h1, 2, '0, '0, 1'b0);
      repeat (30) @(posedge clk);
      cmp("held young", 32'd4, 32'(sink.npkts));
      rtc <= rtc + pkt_asm_pkg::GEN_LIMIT_TICKS;
      wait_pkt(5);
      chk_pkt(2'h1, 2, '0, 8'h04);
      $display("test age done");
   endtask : t_age
   task automatic t_late;
      sink.hold = 1'b1;
      cmp("on time", 32'd0, 32'(commit_late));
      send(8'h21, 8'h06, 2'h1, 2, '0, '0, 1'b1);
      repeat (10) @(posedge clk);
      rtc <= rtc + pkt_asm_pkg::COMMIT_TICKS + 48'd1;
      repeat (2) @(posedge clk);
      sink.hold = 1'b0;
      wait_pkt(6);
      repeat (3) @(posedge clk);
      cmp("late", 32'd1, 32'(commit_late));
      send(8'h03, 8'h06, 2'h0, 1, '0, '0, 1'b1);
      wait_pkt(7);
      send(8'h21, 8'h06, 2'h1, 1, '0, '0, 1'b1);
      repeat (20) @(posedge clk);
      cmp("after root", 32'd3, 32'(n_oerr));
      $display("test late done");
   endtask : t_late
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   // reset, start a recording, run the scenarios
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      {rec_start, index_en} <= 2'b11;
      @(posedge clk);
      rec_start <= 1'b0;
      t_setup();
      t_order();
      t_age();
      t_late();
      print_verdict();
   end
endmodule : tb_top
